// File: inc/fsl_pkg.sv
// Purpose: constants and types for the fieldbus status led sequencer
// Assumes: 40 MHz sys_clk, Avalon-MM register slave with 32-bit data
// Notes: pattern phase lengths are kept in milliseconds
package fsl_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

    // phase lengths in ms
    localparam logic [15:0] FLICKER_MS = 16'h0032;
    localparam logic [15:0] SHORT_MS = 16'h00c8;
    localparam logic [15:0] LONG_MS = 16'h03e8;
    localparam logic [15:0] CYC_MS = 16'h01f4;
    localparam logic [15:0] ACYC_ON_MS = 16'h0064;
    localparam logic [15:0] ACYC_OFF1_MS = 16'h012c;
    localparam logic [15:0] ACYC_OFF2_MS = 16'h02bc;

    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_COND = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    localparam int COND_W = 16;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [COND_W-1:0] COND_RST = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // status field positions
    localparam int ST_RED = 0;
    localparam int ST_GREEN = 1;
    localparam int ST_PAT = 2;
    localparam int ST_COL = 5;
    localparam int ST_PHASE = 7;

    typedef enum logic [1:0] {
        MODE_CO_MASTER,
        MODE_CO_SLAVE,
        MODE_DP_MASTER,
        MODE_DP_SLAVE
    } fsl_mode_e;

    typedef enum logic [2:0] {
        PAT_OFF,
        PAT_ON,
        PAT_FLICKER,
        PAT_BLINK,
        PAT_SFLASH,
        PAT_DFLASH,
        PAT_CYC,
        PAT_ACYC
    } fsl_pat_e;

    typedef enum logic [1:0] {
        COL_GREEN,
        COL_RED,
        COL_ALT
    } fsl_col_e;

    typedef struct packed {
        fsl_pat_e pat;
        fsl_col_e col;
    } fsl_ind_s;

    // condition register, bit 0 is co_reset
    typedef struct packed {
        logic sl_not_cfg;
        logic sl_stop_err;
        logic sl_wrong_cfg;
        logic sl_run;
        logic dm_disconn;
        logic dm_lost;
        logic dm_all_ok;
        logic dm_not_released;
        logic dm_no_cfg;
        logic co_autobaud;
        logic co_busoff;
        logic co_err_ctrl;
        logic co_warn;
        logic co_oper;
        logic co_preop;
        logic co_stopped;
        logic co_reset;
    } fsl_cond_raw_s;

    typedef struct packed {
        logic red;
        logic green;
    } fsl_led_s;

    typedef struct packed {
        logic lit;
        logic last;
        logic [15:0] len_ms;
    } fsl_phase_s;

endpackage

// File: design/fsl_led_seq.sv
// Purpose: duo red/green communication led sequencer with Avalon-MM registers
// Assumes: firmware writes protocol mode and condition bits over the bus
// Notes: one millisecond tick drives all pattern phases
module fsl_led_seq
    import fsl_pkg::*;
#(
    parameter int MS_CYCLES = CYC_PER_MS
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output fsl_led_s led
);

    logic [16:0] cond_raw_r;
    fsl_cond_raw_s cond;
    fsl_mode_e mode_r;
    fsl_ind_s ind_r;
    fsl_ind_s sel;
    fsl_phase_s ph;
    logic [1:0] phase_r;
    logic [15:0] ms_cnt_r;
    logic [31:0] pre_cnt_r;
    logic ms_tick;
    logic restart;
    logic ack_r;
    logic [31:0] bmask;
    logic [31:0] rd_nxt;
    logic wr_go;

    assign cond = fsl_cond_raw_s'(cond_raw_r);

    // bus answer one cycle after request
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_mask
            assign bmask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mode_r <= fsl_mode_e'(CTRL_RST);
        else if (wr_go && avs_address == REG_CTRL && avs_byteenable[0])
            mode_r <= fsl_mode_e'(avs_writedata[1:0]);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cond_raw_r <= {1'b0, COND_RST};
        else if (wr_go && avs_address == REG_COND)
            cond_raw_r <= ((cond_raw_r & ~bmask[16:0])
                | (avs_writedata[16:0] & bmask[16:0]));
    end

    always_comb
    begin
        rd_nxt = RD_ZERO;
        case (avs_address)
            REG_CTRL: rd_nxt[1:0] = mode_r;
            REG_COND: rd_nxt[16:0] = cond_raw_r;
            REG_STATUS:
            begin
                rd_nxt[ST_RED] = led.red;
                rd_nxt[ST_GREEN] = led.green;
                rd_nxt[ST_PAT +: 3] = ind_r.pat;
                rd_nxt[ST_COL +: 2] = ind_r.col;
                rd_nxt[ST_PHASE +: 2] = phase_r;
            end
            default: rd_nxt = RD_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            avs_readdata <= RD_ZERO;
        else if (avs_read && !ack_r)
            avs_readdata <= rd_nxt;
    end

    // indication selection by mode and priority
    always_comb
    begin
        sel = '{pat: PAT_OFF, col: COL_GREEN};
        case (mode_r)
            MODE_CO_MASTER, MODE_CO_SLAVE:
            begin
                if (cond.co_reset)
                    sel = '{pat: PAT_OFF, col: COL_GREEN};
                else if (cond.co_busoff)
                    sel = '{pat: PAT_ON, col: COL_RED};
                else if (cond.co_err_ctrl)
                    sel = '{pat: PAT_DFLASH, col: COL_RED};
                else if (cond.co_warn)
                    sel = '{pat: PAT_SFLASH, col: COL_RED};
                else if (cond.co_autobaud && mode_r == MODE_CO_SLAVE)
                    sel = '{pat: PAT_FLICKER, col: COL_ALT};
                else if (cond.co_oper)
                    sel = '{pat: PAT_ON, col: COL_GREEN};
                else if (cond.co_preop)
                    sel = '{pat: PAT_BLINK, col: COL_GREEN};
                else if (cond.co_stopped)
                    sel = '{pat: PAT_SFLASH, col: COL_GREEN};
            end
            MODE_DP_MASTER:
            begin
                if (cond.dm_disconn)
                    sel = '{pat: PAT_ON, col: COL_RED};
                else if (cond.dm_lost)
                    sel = '{pat: PAT_CYC, col: COL_RED};
                else if (cond.dm_no_cfg)
                    sel = '{pat: PAT_ACYC, col: COL_GREEN};
                else if (cond.dm_not_released)
                    sel = '{pat: PAT_CYC, col: COL_GREEN};
                else if (cond.dm_all_ok)
                    sel = '{pat: PAT_ON, col: COL_GREEN};
            end
            MODE_DP_SLAVE:
            begin
                if (cond.sl_wrong_cfg)
                    sel = '{pat: PAT_ON, col: COL_RED};
                else if (cond.sl_stop_err)
                    sel = '{pat: PAT_CYC, col: COL_RED};
                else if (cond.sl_not_cfg)
                    sel = '{pat: PAT_ACYC, col: COL_RED};
                else if (cond.sl_run)
                    sel = '{pat: PAT_ON, col: COL_GREEN};
            end
            default: sel = '{pat: PAT_OFF, col: COL_GREEN};
        endcase
    end

    assign restart = (sel != ind_r);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ind_r <= '{pat: PAT_OFF, col: COL_GREEN};
        else
            ind_r <= sel;
    end

    // phase table per pattern
    always_comb
    begin
        ph = '{lit: 1'b0, last: 1'b1, len_ms: LONG_MS};
        case (ind_r.pat)
            PAT_OFF: ph = '{lit: 1'b0, last: 1'b1, len_ms: LONG_MS};
            PAT_ON: ph = '{lit: 1'b1, last: 1'b1, len_ms: LONG_MS};
            PAT_FLICKER:
                ph = '{lit: ~phase_r[0], last: phase_r[0], len_ms: FLICKER_MS};
            PAT_BLINK:
                ph = '{lit: ~phase_r[0], last: phase_r[0], len_ms: SHORT_MS};
            PAT_SFLASH:
                ph = '{lit: ~phase_r[0], last: phase_r[0],
                    len_ms: phase_r[0] ? LONG_MS : SHORT_MS};
            PAT_DFLASH:
                ph = '{lit: ~phase_r[0], last: phase_r == 2'h3,
                    len_ms: (phase_r == 2'h3) ? LONG_MS : SHORT_MS};
            PAT_CYC:
                ph = '{lit: ~phase_r[0], last: phase_r[0], len_ms: CYC_MS};
            PAT_ACYC:
                ph = '{lit: ~phase_r[0], last: phase_r == 2'h3,
                    len_ms: (phase_r == 2'h1) ? ACYC_OFF1_MS
                        : (phase_r == 2'h3) ? ACYC_OFF2_MS : ACYC_ON_MS};
            default: ph = '{lit: 1'b0, last: 1'b1, len_ms: LONG_MS};
        endcase
    end

    assign ms_tick = (pre_cnt_r == 32'(MS_CYCLES - 1));

    always_ff @(posedge sys_clk)
    begin
        if (rst || restart || ms_tick)
            pre_cnt_r <= 32'h0000_0000;
        else
            pre_cnt_r <= pre_cnt_r + 32'h0000_0001;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || restart)
        begin
            ms_cnt_r <= 16'h0000;
            phase_r <= 2'h0;
        end
        else if (ms_tick)
        begin
            if (ms_cnt_r == ph.len_ms - 16'h0001)
            begin
                ms_cnt_r <= 16'h0000;
                phase_r <= ph.last ? 2'h0 : phase_r + 2'h1;
            end
            else
                ms_cnt_r <= ms_cnt_r + 16'h0001;
        end
    end

    // one colour at most, alternate shows red lit and green dark
    always_ff @(posedge sys_clk)
    begin
        if (rst || restart)
            led <= '{red: 1'b0, green: 1'b0};
        else
        begin
            led.red <= ph.lit && ind_r.col != COL_GREEN;
            led.green <= (ph.lit && ind_r.col == COL_GREEN)
                || (!ph.lit && ind_r.col == COL_ALT && ind_r.pat == PAT_FLICKER);
        end
    end

    AST_NEVER_BOTH: assert property (@(posedge sys_clk) disable iff (rst)
        !(led.red && led.green)) else $error("red and green lit together");
    AST_CO_RESET_DARK: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r inside {MODE_CO_MASTER, MODE_CO_SLAVE} && cond.co_reset)[*2]
        |=> !led.red && !led.green) else $error("led lit during reset");
    AST_BUSOFF_RED: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r == MODE_CO_MASTER && !cond.co_reset && cond.co_busoff)[*2]
        |=> led.red && !led.green) else $error("bus-off not steady red");
    AST_ERRCTRL_DF: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r inside {MODE_CO_MASTER, MODE_CO_SLAVE} && !cond.co_reset && !cond.co_busoff
        && cond.co_err_ctrl) |=> ind_r == fsl_ind_s'{pat: PAT_DFLASH, col: COL_RED})
        else $error("error event not red double flash");
    AST_WARN_OVER_GREEN: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r == MODE_CO_MASTER && cond == 17'h0_0018)
        |=> ind_r == fsl_ind_s'{pat: PAT_SFLASH, col: COL_RED})
        else $error("warning not above operational");
    AST_PREOP_BLINK: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r == MODE_CO_MASTER && cond == 17'h0_0004)
        |=> ind_r == fsl_ind_s'{pat: PAT_BLINK, col: COL_GREEN})
        else $error("preoperational not green blink");
    AST_PHASE_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        (ms_tick && !restart && $changed(phase_r) == 0 && ms_cnt_r != ph.len_ms - 16'h0001)
        |=> ms_cnt_r == $past(ms_cnt_r) + 16'h0001)
        else $error("ms counter slipped");
    AST_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
        restart |=> phase_r == 2'h0 && ms_cnt_r == 16'h0000)
        else $error("pattern not restarted");
    AST_DM_DISCONN: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_r == MODE_DP_MASTER && cond.dm_disconn)
        |=> ind_r == fsl_ind_s'{pat: PAT_ON, col: COL_RED})
        else $error("disconnect not steady red");
    AST_FLICK_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        (ind_r.pat == PAT_FLICKER && !restart && ms_tick
        && ms_cnt_r == FLICKER_MS - 16'h0001) |=> phase_r != $past(phase_r))
        else $error("flicker phase length wrong");

    COV_DFLASH_END: cover property (@(posedge sys_clk)
        ind_r.pat == PAT_DFLASH && phase_r == 2'h3 && ms_tick);
    COV_ALT_GREEN: cover property (@(posedge sys_clk)
        ind_r.col == COL_ALT && led.green);
    COV_DP_CYC: cover property (@(posedge sys_clk)
        ind_r.pat == PAT_CYC && led.red);
    COV_BUS_WRITE: cover property (@(posedge sys_clk) wr_go);

endmodule

// File: bench/fsl_led_model.sv
// Purpose: duo red/green status led seen from the far side
// Assumes: both colour drives active high
// Notes: flags any cycle with both colours lit
module fsl_led_model
    import fsl_pkg::*;
(
    input wire logic sys_clk,
    input wire fsl_led_s led,
    output logic both_lit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial both_lit = 1'b0;

    always @(posedge sys_clk)
    begin
        if (led.red === 1'b1 && led.green === 1'b1)
        begin
            both_lit = 1'b1;
        end
    end
endmodule

// File: bench/fsl_led_seq_test.sv
// Purpose: self-checking bench for the status led sequencer
// Assumes: MS_CYCLES shortened to 4 cycles per millisecond
// Notes: phase lengths measured from led edges
module fsl_led_seq_test
    import fsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MS = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    fsl_led_s led;
    logic both_lit;
    logic [31:0] rd;
    int fail_count = 0;
    int compares = 0;

    always #12.5 sys_clk = ~sys_clk;

    fsl_led_seq #(.MS_CYCLES(MS)) DUT (
        .sys_clk(sys_clk),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .led(led)
    );

    fsl_led_model partner (.sys_clk(sys_clk), .led(led), .both_lit(both_lit));

    task automatic end_of_test();
        if (fail_count == 0 && compares > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    // one avalon access, held until waitrequest seen low
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int i;
        @(posedge sys_clk);
        avs_address <= addr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= data;
        avs_byteenable <= 4'hf;
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0)
            begin
                rd = avs_readdata;
                break;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20)
        begin
            check(1'b0, "bus timeout");
            end_of_test();
        end
    endtask

    // select an indication, then check steady level when n is 0, else restart and phase lengths
    task automatic run_case(input logic [1:0] mode, input logic [31:0] cond, input logic sel,
        input logic [1:0] steady, input int n, input int ms[4], input logic alt);
        int i;
        int k;
        int cnt;
        logic prev;
        logic cur;
        logic bad;
        bad = 1'b0;
        bus(1'b1, REG_CTRL, {30'h0000_0000, mode});
        bus(1'b1, REG_COND, cond);
        if (n == 0)
        begin
            repeat (8) @(negedge sys_clk);
            for (i = 0; i < 1000; i++)
            begin
                @(negedge sys_clk);
                if (led !== steady)
                begin
                    break;
                end
            end
            check(i == 1000, "steady level wrong");
            return;
        end
        prev = sel ? led.red : led.green;
        cur = prev;
        for (i = 0; i < 8; i++)
        begin
            @(negedge sys_clk);
            cur = sel ? led.red : led.green;
            if (prev === 1'b0 && cur === 1'b1)
            begin
                break;
            end
            prev = cur;
        end
        check(i < 8, "pattern did not restart lit");
        if (i == 8)
        begin
            return;
        end
        for (k = 0; k < n; k++)
        begin
            cnt = 0;
            prev = cur;
            while (cur === prev && cnt < 5000)
            begin
                if (alt && led !== {cur, ~cur})
                begin
                    bad = 1'b1;
                end
                @(negedge sys_clk);
                cnt++;
                cur = sel ? led.red : led.green;
            end
            check(cnt == ms[k] * MS, "phase length wrong");
        end
        check(!bad, "colours not alternating");
    endtask

    initial
    begin
        repeat (9) @(posedge sys_clk);
        @(negedge sys_clk);
        check(led === 2'b00, "led lit in reset");
        @(posedge sys_clk);
        rst <= 1'b0;
        run_case(2'h0, 32'h0000_0002, 1'b0, 2'h0, 2, '{200, 1000, 0, 0}, 1'b0);
        run_case(2'h0, 32'h0000_0004, 1'b0, 2'h0, 2, '{200, 200, 0, 0}, 1'b0);
        run_case(2'h0, 32'h0000_0008, 1'b0, 2'h1, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h0, 32'h0000_0018, 1'b1, 2'h0, 2, '{200, 1000, 0, 0}, 1'b0);
        run_case(2'h0, 32'h0000_0020, 1'b1, 2'h0, 4, '{200, 200, 200, 1000}, 1'b0);
        run_case(2'h0, 32'h0000_0078, 1'b1, 2'h2, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h0, 32'h0000_0041, 1'b0, 2'h0, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h1, 32'h0000_0080, 1'b1, 2'h0, 2, '{50, 50, 0, 0}, 1'b1);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        check(rd[6:2] === {2'h2, 3'h2}, "status pattern wrong");
        run_case(2'h1, 32'h0000_0000, 1'b0, 2'h0, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h2, 32'h0000_0100, 1'b0, 2'h0, 4, '{100, 300, 100, 700}, 1'b0);
        run_case(2'h2, 32'h0000_0200, 1'b0, 2'h0, 2, '{500, 500, 0, 0}, 1'b0);
        run_case(2'h2, 32'h0000_0400, 1'b0, 2'h1, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h2, 32'h0000_0800, 1'b1, 2'h0, 2, '{500, 500, 0, 0}, 1'b0);
        run_case(2'h2, 32'h0000_1000, 1'b1, 2'h2, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h3, 32'h0000_2000, 1'b0, 2'h1, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h3, 32'h0000_4000, 1'b1, 2'h2, 0, '{0, 0, 0, 0}, 1'b0);
        run_case(2'h3, 32'h0000_8000, 1'b1, 2'h0, 2, '{500, 500, 0, 0}, 1'b0);
        run_case(2'h3, 32'h0001_0000, 1'b1, 2'h0, 4, '{100, 300, 100, 700}, 1'b0);
        bus(1'b0, REG_CTRL, 32'h0000_0000);
        check(rd[1:0] === 2'h3, "mode readback wrong");
        bus(1'b0, 4'hc, 32'h0000_0000);
        check(rd === RD_ZERO, "unmapped read not zero");
        check(both_lit === 1'b0, "both colours lit together");
        end_of_test();
    end
endmodule
